// ===== design/vip_pkg.sv
// Package: register map, field layout and types of the video input port.
package vip_pkg;
  localparam int AW = 8;
  localparam int DW = 16;
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_SD = 8'h04;
  localparam logic [7:0] REG_OUT = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [15:0] MODE_MASK = 16'h001f;
  localparam logic [15:0] SD_MASK = 16'h003f;
  localparam logic [15:0] OUT_MASK = 16'h1f7f;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] SD_RST = 16'h0000;
  localparam logic [15:0] OUT_RST = 16'h0008;
  localparam int MODE_LSB = 0;
  localparam int EDGE_LSB = 3;
  localparam int SD_RGB_BIT = 0;
  localparam int SD_WIDTH_LSB = 1;
  localparam int SD_COMP_BIT = 3;
  localparam int SD_SWAP_BIT = 4;
  localparam int SD_REV_BIT = 5;
  localparam int OUT_CS_BIT = 0;
  localparam int OUT_HRSWAP_BIT = 1;
  localparam int OUT_TEN_BIT = 2;
  localparam int OUT_PLLPD_BIT = 3;
  localparam int OUT_SDRATE_BIT = 4;
  localparam int OUT_HDRATE_BIT = 5;
  localparam int OUT_HD_BIT = 6;
  localparam int OUT_STD_LSB = 8;
  localparam int ST_PLL_BIT = 0;
  localparam int ST_EMB_BIT = 1;
  localparam int ST_NONSTD_BIT = 2;
  localparam int ST_LVL_LSB = 3;
  localparam int ST_RATE_LSB = 5;
  localparam logic [2:0] MODE_SD = 3'h0;
  localparam logic [2:0] MODE_SDR = 3'h1;
  localparam logic [2:0] MODE_DDR = 3'h2;
  localparam logic [2:0] MODE_ED54 = 3'h7;
  localparam logic [1:0] W8 = 2'h0;
  localparam logic [1:0] W16 = 2'h1;
  localparam logic [1:0] W10 = 2'h2;
  localparam logic [4:0] STD_NONSTD = 5'h01;
  typedef enum logic [3:0] {
    VIP_C_G, VIP_C_B, VIP_C_R, VIP_C_Y, VIP_C_PB, VIP_C_PR,
    VIP_C_CVBS, VIP_C_LUMA, VIP_C_CHROMA
  } vip_comp_t;
  typedef enum logic [2:0] {VIP_X1, VIP_X2, VIP_X4, VIP_X8, VIP_X16} vip_rate_t;
  typedef enum logic [1:0] {VIP_LVL_BLANK, VIP_LVL_SYNC, VIP_LVL_TRI} vip_level_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } vip_bus_t;
  typedef struct packed {
    logic [9:0] y_g;
    logic [9:0] c_b;
    logic [9:0] r;
    logic is_rgb;
  } vip_pixel_t;
  typedef struct packed {
    vip_comp_t dac1;
    vip_comp_t dac2;
    vip_comp_t dac3;
  } vip_dac_map_t;
endpackage

// ===== design/vip_edge_detect.sv
// Rise and fall pulses of the sampled pixel clock level.
`timescale 1ns/1ns
`default_nettype none
module vip_edge_detect (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic prev_reg;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      prev_reg <= 1'b0;
    else
      prev_reg <= level;
  end

  assign rise = level && !prev_reg;
  assign fall = !level && prev_reg;
endmodule
`default_nettype wire

// ===== design/vip_dac_router.sv
// Routing of encoded components onto the three DAC outputs.
`timescale 1ns/1ns
`default_nettype none
module vip_dac_router (
  input wire logic hr_mode,
  input wire logic cs_sel,
  input wire logic comp_en,
  input wire logic lc_swap,
  input wire logic rev,
  input wire logic hr_swap,
  output var vip_pkg::vip_dac_map_t map
);
  wire vip_pkg::vip_dac_map_t gbr = {vip_pkg::VIP_C_G, vip_pkg::VIP_C_B, vip_pkg::VIP_C_R};
  wire vip_pkg::vip_dac_map_t ypp = {vip_pkg::VIP_C_Y, vip_pkg::VIP_C_PB, vip_pkg::VIP_C_PR};
  wire vip_pkg::vip_dac_map_t grb = {vip_pkg::VIP_C_G, vip_pkg::VIP_C_R, vip_pkg::VIP_C_B};
  wire vip_pkg::vip_dac_map_t ypr = {vip_pkg::VIP_C_Y, vip_pkg::VIP_C_PR, vip_pkg::VIP_C_PB};
  wire vip_pkg::vip_dac_map_t rbg = {vip_pkg::VIP_C_R, vip_pkg::VIP_C_B, vip_pkg::VIP_C_G};
  wire vip_pkg::vip_dac_map_t cyc = {vip_pkg::VIP_C_CVBS, vip_pkg::VIP_C_LUMA,
                                     vip_pkg::VIP_C_CHROMA};
  wire vip_pkg::vip_dac_map_t ccy = {vip_pkg::VIP_C_CVBS, vip_pkg::VIP_C_CHROMA,
                                     vip_pkg::VIP_C_LUMA};
  // Composite select without component output is not a listed setting; it falls to RGB.
  wire vip_pkg::vip_dac_map_t sd_rgb = rev ? rbg : gbr;
  wire vip_pkg::vip_dac_map_t sd_cmp = lc_swap ? ccy : cyc;
  wire vip_pkg::vip_dac_map_t sd_map = !cs_sel ? sd_rgb : (comp_en ? sd_cmp : ypp);
  wire vip_pkg::vip_dac_map_t hr_rgb = hr_swap ? grb : gbr;
  wire vip_pkg::vip_dac_map_t hr_yuv = hr_swap ? ypr : ypp;
  assign map = hr_mode ? (cs_sel ? hr_yuv : hr_rgb) : sd_map;
endmodule
`default_nettype wire

// ===== design/vip_port.sv
// Video input port: mode registers, pixel capture, sync levels and DAC routing.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module vip_port #(
  parameter bit NARROW_PORT = 1'b0
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire vip_pkg::vip_bus_t bus_req,
  output logic [15:0] bus_rdata,
  input wire logic pixel_clock_input,
  input wire logic [15:0] pixel_bus,
  input wire logic hsync_n,
  input wire logic vsync_n,
  output var vip_pkg::vip_pixel_t pixel_out,
  output logic pixel_valid,
  output logic hsync_out_n,
  output logic vsync_out_n,
  output logic embedded_code_enable,
  output var vip_pkg::vip_level_t sync_level,
  output var vip_pkg::vip_dac_map_t dac_map,
  output logic pll_enable,
  output var vip_pkg::vip_rate_t oversample_rate
);
  logic [15:0] mode_reg;
  logic [15:0] sd_reg;
  logic [15:0] out_reg;
  logic [15:0] rdata_reg;
  logic pclk_rise;
  logic pclk_fall;
  logic phase_reg;
  logic phase_next;
  logic valid_reg;
  logic valid_next;
  logic hs_reg;
  logic vs_reg;
  vip_pkg::vip_pixel_t pix_reg;
  vip_pkg::vip_pixel_t pix_next;
  vip_pkg::vip_level_t lvl_reg;
  vip_pkg::vip_level_t lvl_next;
  vip_pkg::vip_rate_t rate;

  // Register decode.
  wire hit_mode = bus_req.addr == vip_pkg::REG_MODE;
  wire hit_sd = bus_req.addr == vip_pkg::REG_SD;
  wire hit_out = bus_req.addr == vip_pkg::REG_OUT;
  wire hit_stat = bus_req.addr == vip_pkg::REG_STAT;
  wire wr_mode = bus_req.wr && hit_mode;
  wire wr_sd = bus_req.wr && hit_sd;
  wire wr_out = bus_req.wr && hit_out;

  // Configuration fields.
  wire [2:0] in_mode = mode_reg[vip_pkg::MODE_LSB +: 3];
  wire [1:0] edge_sel = mode_reg[vip_pkg::EDGE_LSB +: 2];
  wire sd_rgb_input_select = sd_reg[vip_pkg::SD_RGB_BIT];
  wire [1:0] sd_width = sd_reg[vip_pkg::SD_WIDTH_LSB +: 2];
  wire output_colour_space_select = out_reg[vip_pkg::OUT_CS_BIT];
  wire high_res_colour_output_exchange = out_reg[vip_pkg::OUT_HRSWAP_BIT];
  wire high_res_ten_bit_select = out_reg[vip_pkg::OUT_TEN_BIT];
  wire pll_off = out_reg[vip_pkg::OUT_PLLPD_BIT];
  wire sd_rate_sel = out_reg[vip_pkg::OUT_SDRATE_BIT];
  wire hd_rate_sel = out_reg[vip_pkg::OUT_HDRATE_BIT];
  wire hd_out = out_reg[vip_pkg::OUT_HD_BIT];
  wire [4:0] hr_std = out_reg[vip_pkg::OUT_STD_LSB +: 5];

  // Mode decode.
  wire is_sd = in_mode == vip_pkg::MODE_SD;
  wire is_sdr = in_mode == vip_pkg::MODE_SDR;
  wire is_ddr = in_mode == vip_pkg::MODE_DDR;
  wire is_ed54 = in_mode == vip_pkg::MODE_ED54;
  wire is_hr = is_sdr || is_ddr;
  wire sd_wide = is_sd && (sd_rgb_input_select || sd_width == vip_pkg::W16);
  wire interleaved = (is_sd && !sd_wide) || is_ed54;
  wire nonstd = is_hr && hr_std == vip_pkg::STD_NONSTD;

  // Word extraction from the pixel bus.
  wire [9:0] byte_hi = {pixel_bus[15:8], 2'h0};
  wire [9:0] byte_lo = {pixel_bus[7:0], 2'h0};
  wire [9:0] word_hi = pixel_bus[15:6];
  wire [9:0] sd_word = (sd_width == vip_pkg::W10) ? word_hi : byte_hi;
  wire [9:0] hr_word = high_res_ten_bit_select ? word_hi : byte_hi;
  // The narrow package has no upper pins, so its 54 MHz mode takes 8-bit words from the lower byte.
  wire [9:0] ed54_word = NARROW_PORT ? byte_lo : hr_word;
  wire [9:0] il_word = is_ed54 ? ed54_word : sd_word;
  wire vip_pkg::vip_pixel_t ycc16 = {byte_hi, byte_lo, 10'h000, 1'b0};
  wire vip_pkg::vip_pixel_t rgb16 = {pixel_bus[10:5], 4'h0, pixel_bus[15:11], 5'h00,
                                     pixel_bus[4:0], 5'h00, 1'b1};

  // Dual rate edge choice: bit 0 of the edge field moves luma to the falling edge.
  wire luma_fall = edge_sel[0];
  wire luma_evt = luma_fall ? pclk_fall : pclk_rise;
  wire chroma_evt = luma_fall ? pclk_rise : pclk_fall;

  vip_edge_detect u_edge (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .level(pixel_clock_input),
    .rise(pclk_rise),
    .fall(pclk_fall)
  );

  vip_dac_router u_dac (
    .hr_mode(!is_sd),
    .cs_sel(output_colour_space_select),
    .comp_en(sd_reg[vip_pkg::SD_COMP_BIT]),
    .lc_swap(sd_reg[vip_pkg::SD_SWAP_BIT]),
    .rev(sd_reg[vip_pkg::SD_REV_BIT]),
    .hr_swap(high_res_colour_output_exchange),
    .map(dac_map)
  );

  // Software-visible registers.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_reg <= vip_pkg::MODE_RST;
      sd_reg <= vip_pkg::SD_RST;
      out_reg <= vip_pkg::OUT_RST;
    end
    else
    begin
      if (wr_mode)
        mode_reg <= bus_req.wdata & vip_pkg::MODE_MASK;
      if (wr_sd)
        sd_reg <= bus_req.wdata & vip_pkg::SD_MASK;
      if (wr_out)
        out_reg <= bus_req.wdata & vip_pkg::OUT_MASK;
    end
  end

  wire [15:0] stat_value = {8'h00, rate, lvl_reg, nonstd, embedded_code_enable, pll_enable};
  wire [15:0] rd_value = hit_mode ? mode_reg :
                         hit_sd ? sd_reg :
                         hit_out ? out_reg :
                         hit_stat ? stat_value : 16'h0000;

  // Read data stand only in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_reg <= 16'h0000;
    else
      rdata_reg <= bus_req.rd ? rd_value : 16'h0000;
  end

  // Pixel assembly.
  always_comb
  begin
    pix_next = pix_reg;
    valid_next = 1'b0;
    phase_next = phase_reg;
    if (pclk_rise && interleaved)
    begin
      phase_next = !phase_reg;
      pix_next.is_rgb = 1'b0;
      pix_next.r = 10'h000;
      if (!phase_reg)
        pix_next.c_b = il_word;
      else
      begin
        pix_next.y_g = il_word;
        valid_next = 1'b1;
      end
    end
    else if (pclk_rise && sd_wide)
    begin
      phase_next = !phase_reg;
      if (!phase_reg)
      begin
        pix_next = sd_rgb_input_select ? rgb16 : ycc16;
        valid_next = 1'b1;
      end
    end
    else if (pclk_rise && is_sdr)
    begin
      pix_next = ycc16;
      valid_next = 1'b1;
    end
    else if (is_ddr && luma_evt)
    begin
      pix_next.y_g = hr_word;
      pix_next.r = 10'h000;
      pix_next.is_rgb = 1'b0;
    end
    else if (is_ddr && chroma_evt)
    begin
      pix_next.c_b = hr_word;
      valid_next = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pix_reg <= '0;
      valid_reg <= 1'b0;
      phase_reg <= 1'b0;
    end
    else
    begin
      pix_reg <= pix_next;
      valid_reg <= valid_next;
      phase_reg <= phase_next;
    end
  end

  // Sync inputs are taken on the pixel clock rise, idle high until then.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hs_reg <= 1'b1;
      vs_reg <= 1'b1;
    end
    else if (pclk_rise)
    begin
      hs_reg <= hsync_n;
      vs_reg <= vsync_n;
    end
  end

  // Output level in nonstandard timing follows the sync edges alone.
  wire hs_fell = pclk_rise && hs_reg && !hsync_n;
  wire hs_rose = pclk_rise && !hs_reg && hsync_n;
  wire vs_rose = pclk_rise && !vs_reg && vsync_n;

  always_comb
  begin
    lvl_next = lvl_reg;
    if (!nonstd)
      lvl_next = vip_pkg::VIP_LVL_BLANK;
    else
    begin
      case (lvl_reg)
        vip_pkg::VIP_LVL_BLANK:
          if (hs_fell)
            lvl_next = vip_pkg::VIP_LVL_SYNC;
        vip_pkg::VIP_LVL_SYNC:
          if (hs_rose)
            lvl_next = vip_pkg::VIP_LVL_BLANK;
          else if (vs_rose)
            lvl_next = vip_pkg::VIP_LVL_TRI;
        vip_pkg::VIP_LVL_TRI:
          if (hs_rose)
            lvl_next = vip_pkg::VIP_LVL_BLANK;
        default:
          lvl_next = vip_pkg::VIP_LVL_BLANK;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      lvl_reg <= vip_pkg::VIP_LVL_BLANK;
    else
      lvl_reg <= lvl_next;
  end

  // Oversampling rate from the PLL state and the rate selects.
  always_comb
  begin
    rate = vip_pkg::VIP_X1;
    if (is_sd)
      rate = pll_off ? vip_pkg::VIP_X2 : (sd_rate_sel ? vip_pkg::VIP_X8 : vip_pkg::VIP_X16);
    else if ((is_hr && !hd_out) || is_ed54)
      rate = pll_off ? vip_pkg::VIP_X1 : (sd_rate_sel ? vip_pkg::VIP_X4 : vip_pkg::VIP_X8);
    else if (is_hr)
      rate = pll_off ? vip_pkg::VIP_X1 : (hd_rate_sel ? vip_pkg::VIP_X2 : vip_pkg::VIP_X4);
  end

  assign bus_rdata = rdata_reg;
  assign pixel_out = pix_reg;
  assign pixel_valid = valid_reg;
  assign sync_level = lvl_reg;
  assign oversample_rate = rate;
  assign pll_enable = !pll_off;
  // Embedded codes are never decoded in the wide SD modes or nonstandard timing.
  assign embedded_code_enable = !sd_wide && !nonstd && (is_sd || is_hr || is_ed54);
  // In 54 MHz mode the sync pins are ignored and the outputs sit idle high.
  assign hsync_out_n = is_ed54 ? 1'b1 : hs_reg;
  assign vsync_out_n = is_ed54 ? 1'b1 : vs_reg;

  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  pll_write_a: assert property (
    wr_out |=> pll_enable == !$past(bus_req.wdata[vip_pkg::OUT_PLLPD_BIT]))
    else $error("PLL enable does not follow the written power bit");

  sdr_capture_a: assert property (
    pclk_rise && is_sdr |=> pixel_valid && pixel_out.y_g == {$past(pixel_bus[15:8]), 2'h0}
      && pixel_out.c_b == {$past(pixel_bus[7:0]), 2'h0})
    else $error("Single rate pixel not captured from the expected lanes");

  sd8_luma_a: assert property (
    pclk_rise && is_sd && !sd_wide && sd_width == vip_pkg::W8 && phase_reg
      |=> pixel_valid && pixel_out.y_g == {$past(pixel_bus[15:8]), 2'h0})
    else $error("SD 8-bit luma not taken from the upper byte");

  sd10_chroma_a: assert property (
    pclk_rise && is_sd && !sd_wide && sd_width == vip_pkg::W10 && !phase_reg
      |=> !pixel_valid && pixel_out.c_b == $past(pixel_bus[15:6]))
    else $error("SD 10-bit chroma not taken from bits 15 to 6");

  rgb_lanes_a: assert property (
    pclk_rise && is_sd && sd_rgb_input_select && !phase_reg
      |=> pixel_out.is_rgb && pixel_out.r == {$past(pixel_bus[4:0]), 5'h00}
      && pixel_out.y_g == {$past(pixel_bus[10:5]), 4'h0})
    else $error("SD RGB components not taken from their lanes");

  half_rate_a: assert property (
    pixel_valid && is_sd && sd_wide && $stable(in_mode) |=> !pixel_valid)
    else $error("Wide SD pixels arrive faster than half the clock rate");

  ddr_luma_a: assert property (
    is_ddr && luma_evt && !high_res_ten_bit_select
      |=> !pixel_valid && pixel_out.y_g == {$past(pixel_bus[15:8]), 2'h0})
    else $error("Dual rate luma not captured on the selected edge");

  ed54_sync_a: assert property (
    is_ed54 && pclk_rise && !hsync_n |=> hsync_out_n && vsync_out_n)
    else $error("Sync inputs leak through in 54 MHz mode");

  nonstd_codes_a: assert property (
    wr_out && is_hr && bus_req.wdata[vip_pkg::OUT_STD_LSB +: 5] == vip_pkg::STD_NONSTD
      |=> !embedded_code_enable)
    else $error("Embedded codes still honoured in nonstandard timing");

  sync_level_a: assert property (
    nonstd && lvl_reg == vip_pkg::VIP_LVL_BLANK && hs_fell
      |=> sync_level == vip_pkg::VIP_LVL_SYNC)
    else $error("Falling horizontal sync did not enter the sync level");

  sd_route_a: assert property (
    is_sd && output_colour_space_select && sd_reg[vip_pkg::SD_COMP_BIT]
      |-> dac_map.dac1 == vip_pkg::VIP_C_CVBS)
    else $error("Composite not routed to the first DAC");

  rate_off_a: assert property (
    pll_off && is_sd |-> oversample_rate == vip_pkg::VIP_X2)
    else $error("SD rate with PLL off is not 2x");
endmodule
`default_nettype wire

// ===== tb/vip_source.sv
// Behavioural pixel source that drives the capture side of the video input port.
`timescale 1ns/1ns
`default_nettype none
module vip_source (
  input wire logic mclk,
  output logic pixel_clock_input,
  output logic [15:0] pixel_bus,
  output logic hsync_n,
  output logic vsync_n
);
  initial
  begin
    pixel_clock_input = 1'b0;
    pixel_bus = 16'h0000;
    hsync_n = 1'b1;
    vsync_n = 1'b1;
  end
  // Each level is held for two edges so that it is seen whatever the sample phase.
  // Once the hold runs out the bus shows the inverse, so stale data cannot pass for fresh.
  task automatic drive(input logic lvl, input logic [15:0] d);
    @(posedge mclk);
    pixel_clock_input <= lvl;
    pixel_bus <= d;
    @(posedge mclk);
    @(posedge mclk);
    pixel_bus <= ~d;
  endtask
  task automatic pulse(input logic [15:0] d);
    drive(1'b1, d);
    drive(1'b0, ~d);
  endtask
  // The source makes every sync edge itself in the 16-bit and nonstandard modes.
  task automatic set_sync(input logic h, input logic v);
    @(posedge mclk);
    hsync_n <= h;
    vsync_n <= v;
  endtask
endmodule
`default_nettype wire

// ===== tb/vip_port_bench.sv
// Self-checking bench for the video input port and its DAC routing.
`timescale 1ns/1ns
`default_nettype none
module vip_port_bench;
  logic mclk;
  logic sys_rst;
  vip_pkg::vip_bus_t bus_req;
  logic [15:0] bus_rdata;
  logic pixel_clock_input;
  logic [15:0] pixel_bus;
  logic hsync_n;
  logic vsync_n;
  vip_pkg::vip_pixel_t pixel_out;
  vip_pkg::vip_pixel_t last_pix;
  vip_pkg::vip_pixel_t narrow_out;
  vip_pkg::vip_pixel_t narrow_pix;
  logic narrow_valid;
  logic pixel_valid;
  logic hsync_out_n;
  logic vsync_out_n;
  logic embedded_code_enable;
  vip_pkg::vip_level_t sync_level;
  vip_pkg::vip_dac_map_t dac_map;
  logic pll_enable;
  vip_pkg::vip_rate_t oversample_rate;
  int error_cnt = 0;
  int checked = 0;
  int vcnt = 0;

  vip_port #(.NARROW_PORT(1'b0)) uut (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .pixel_clock_input(pixel_clock_input), .pixel_bus(pixel_bus),
    .hsync_n(hsync_n), .vsync_n(vsync_n), .pixel_out(pixel_out), .pixel_valid(pixel_valid),
    .hsync_out_n(hsync_out_n), .vsync_out_n(vsync_out_n),
    .embedded_code_enable(embedded_code_enable), .sync_level(sync_level),
    .dac_map(dac_map), .pll_enable(pll_enable), .oversample_rate(oversample_rate));
  // The narrow package variant shares every input; only its pixels are judged.
  vip_port #(.NARROW_PORT(1'b1)) uut_narrow (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req),
    .bus_rdata(), .pixel_clock_input(pixel_clock_input), .pixel_bus(pixel_bus),
    .hsync_n(hsync_n), .vsync_n(vsync_n), .pixel_out(narrow_out), .pixel_valid(narrow_valid),
    .hsync_out_n(), .vsync_out_n(), .embedded_code_enable(), .sync_level(), .dac_map(),
    .pll_enable(), .oversample_rate());
  vip_source src (.mclk(mclk), .pixel_clock_input(pixel_clock_input),
    .pixel_bus(pixel_bus), .hsync_n(hsync_n), .vsync_n(vsync_n));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Valid is a one-cycle pulse, so every pulse is counted and its pixel kept.
  always @(posedge mclk)
  begin
    if (pixel_valid === 1'b1)
    begin
      vcnt <= vcnt + 1;
      last_pix <= pixel_out;
    end
    if (narrow_valid === 1'b1)
      narrow_pix <= narrow_out;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pix(input vip_pkg::vip_pixel_t got, input vip_pkg::vip_pixel_t exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  task automatic do_reset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask

  task automatic t_regs();
    logic [15:0] d;
    #1;
    cmp(pll_enable, 1'b0);
    cmp(oversample_rate, vip_pkg::VIP_X2);
    cmp(dac_map, {vip_pkg::VIP_C_G, vip_pkg::VIP_C_B, vip_pkg::VIP_C_R});
    rd(vip_pkg::REG_MODE, d);
    cmp(d, 16'h0000);
    rd(vip_pkg::REG_OUT, d);
    cmp(d, 16'h0008);
    wr(vip_pkg::REG_STAT, 16'hffff);
    rd(vip_pkg::REG_STAT, d);
    cmp(d, 16'h0022);
    wr(vip_pkg::REG_MODE, 16'hffff);
    rd(vip_pkg::REG_MODE, d);
    cmp(d, 16'h001f);
    rd(8'h10, d);
    cmp(d, 16'h0000);
    $display("test registers finished");
  endtask

  task automatic t_sd_il();
    int v0;
    do_reset();
    v0 = vcnt;
    src.pulse(16'h5a3c);
    src.pulse(16'hc396);
    #1;
    cmp(vcnt - v0, 1);
    cmp_pix(last_pix, {10'h30c, 10'h168, 10'h000, 1'b0});
    wr(vip_pkg::REG_SD, 16'h0004);
    src.pulse(16'h5aff);
    src.pulse(16'hc3c0);
    #1;
    cmp_pix(last_pix, {10'h30f, 10'h16b, 10'h000, 1'b0});
    $display("test sd interleaved finished");
  endtask

  task automatic t_sd16();
    int v0;
    do_reset();
    wr(vip_pkg::REG_SD, 16'h0002);
    v0 = vcnt;
    src.pulse(16'ha55a);
    src.pulse(16'h0ff0);
    #1;
    cmp(vcnt - v0, 1);
    cmp_pix(last_pix, {10'h294, 10'h168, 10'h000, 1'b0});
    wr(vip_pkg::REG_SD, 16'h0001);
    src.pulse(16'hb6d9);
    src.pulse(16'h0000);
    #1;
    cmp_pix(last_pix, {10'h360, 10'h2c0, 10'h320, 1'b1});
    $display("test sd sixteen bit finished");
  endtask

  task automatic t_sdr();
    int v0;
    do_reset();
    wr(vip_pkg::REG_MODE, 16'h0001);
    src.set_sync(1'b0, 1'b1);
    v0 = vcnt;
    src.pulse(16'h1234);
    src.pulse(16'hfe01);
    #1;
    cmp(vcnt - v0, 2);
    cmp_pix(last_pix, {10'h3f8, 10'h004, 10'h000, 1'b0});
    cmp({hsync_out_n, vsync_out_n}, 2'b01);
    src.set_sync(1'b1, 1'b1);
    $display("test single rate finished");
  endtask

  task automatic t_ddr();
    do_reset();
    wr(vip_pkg::REG_MODE, 16'h0002);
    src.drive(1'b1, 16'h8100);
    src.drive(1'b0, 16'h4200);
    #1;
    cmp_pix(last_pix, {10'h204, 10'h108, 10'h000, 1'b0});
    // Edge field 11 with ten-bit words puts luma on the falling edge.
    wr(vip_pkg::REG_MODE, 16'h001a);
    wr(vip_pkg::REG_OUT, 16'h000c);
    src.drive(1'b1, 16'h0000);
    src.drive(1'b0, 16'hffc0);
    src.drive(1'b1, 16'h0040);
    src.drive(1'b0, 16'h0000);
    #1;
    cmp_pix(last_pix, {10'h3ff, 10'h001, 10'h000, 1'b0});
    $display("test dual rate finished");
  endtask

  task automatic t_ed54();
    do_reset();
    wr(vip_pkg::REG_MODE, 16'h0007);
    wr(vip_pkg::REG_OUT, 16'h000c);
    src.set_sync(1'b0, 1'b0);
    src.pulse(16'h0140);
    src.pulse(16'hffc0);
    #1;
    cmp_pix(last_pix, {10'h3ff, 10'h005, 10'h000, 1'b0});
    cmp_pix(narrow_pix, {10'h300, 10'h100, 10'h000, 1'b0});
    cmp({hsync_out_n, vsync_out_n, embedded_code_enable}, 3'b111);
    src.set_sync(1'b1, 1'b1);
    $display("test ed 54 finished");
  endtask

  task automatic dac(input logic [15:0] m, input logic [15:0] s, input logic [15:0] o,
    input vip_pkg::vip_dac_map_t e);
    wr(vip_pkg::REG_MODE, m);
    wr(vip_pkg::REG_SD, s);
    wr(vip_pkg::REG_OUT, o);
    #1;
    cmp(dac_map, e);
  endtask

  task automatic rate(input logic [15:0] m, input logic [15:0] o, input vip_pkg::vip_rate_t e);
    wr(vip_pkg::REG_MODE, m);
    wr(vip_pkg::REG_OUT, o);
    #1;
    cmp(oversample_rate, e);
    cmp(pll_enable, !o[3]);
  endtask

  task automatic t_out();
    do_reset();
    dac(16'h0, 16'h00, 16'h8, {vip_pkg::VIP_C_G, vip_pkg::VIP_C_B, vip_pkg::VIP_C_R});
    dac(16'h0, 16'h00, 16'h9, {vip_pkg::VIP_C_Y, vip_pkg::VIP_C_PB, vip_pkg::VIP_C_PR});
    dac(16'h0, 16'h08, 16'h9,
      {vip_pkg::VIP_C_CVBS, vip_pkg::VIP_C_LUMA, vip_pkg::VIP_C_CHROMA});
    dac(16'h0, 16'h18, 16'h9,
      {vip_pkg::VIP_C_CVBS, vip_pkg::VIP_C_CHROMA, vip_pkg::VIP_C_LUMA});
    dac(16'h0, 16'h20, 16'h8, {vip_pkg::VIP_C_R, vip_pkg::VIP_C_B, vip_pkg::VIP_C_G});
    dac(16'h1, 16'h00, 16'h8, {vip_pkg::VIP_C_G, vip_pkg::VIP_C_B, vip_pkg::VIP_C_R});
    dac(16'h1, 16'h00, 16'ha, {vip_pkg::VIP_C_G, vip_pkg::VIP_C_R, vip_pkg::VIP_C_B});
    dac(16'h7, 16'h00, 16'h9, {vip_pkg::VIP_C_Y, vip_pkg::VIP_C_PB, vip_pkg::VIP_C_PR});
    dac(16'h2, 16'h00, 16'hb, {vip_pkg::VIP_C_Y, vip_pkg::VIP_C_PR, vip_pkg::VIP_C_PB});
    rate(16'h0, 16'h0010, vip_pkg::VIP_X8);
    rate(16'h0, 16'h0000, vip_pkg::VIP_X16);
    rate(16'h1, 16'h0010, vip_pkg::VIP_X4);
    rate(16'h1, 16'h0000, vip_pkg::VIP_X8);
    rate(16'h1, 16'h0008, vip_pkg::VIP_X1);
    rate(16'h2, 16'h0060, vip_pkg::VIP_X2);
    rate(16'h1, 16'h0040, vip_pkg::VIP_X4);
    rate(16'h7, 16'h0010, vip_pkg::VIP_X4);
    $display("test output routing finished");
  endtask

  // Blanking-level data keeps the source honest while the device inserts none.
  task automatic lvl(input logic h, input logic v, input vip_pkg::vip_level_t e);
    src.set_sync(h, v);
    src.pulse(16'h1080);
    #1;
    cmp(sync_level, e);
  endtask

  task automatic t_nonstd();
    logic [15:0] d;
    do_reset();
    wr(vip_pkg::REG_MODE, 16'h0001);
    wr(vip_pkg::REG_OUT, 16'h0108);
    lvl(1'b1, 1'b0, vip_pkg::VIP_LVL_BLANK);
    cmp(embedded_code_enable, 1'b0);
    rd(vip_pkg::REG_STAT, d);
    cmp(d[2:1], 2'b10);
    lvl(1'b0, 1'b0, vip_pkg::VIP_LVL_SYNC);
    lvl(1'b0, 1'b1, vip_pkg::VIP_LVL_TRI);
    lvl(1'b1, 1'b1, vip_pkg::VIP_LVL_BLANK);
    $display("test nonstandard timing finished");
  endtask

  initial
  begin
    sys_rst = 1'b1;
    bus_req = '0;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs();
    t_sd_il();
    t_sd16();
    t_sdr();
    t_ddr();
    t_ed54();
    t_out();
    t_nonstd();
    stop_test();
  end

  // The whole sequence needs under 300 cycles; this limit is well beyond it.
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
